// *** dv/ipf_checker.sv ***
// Port-level assertions for the priority field block
`timescale 1ns/1ps
module ipf_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ipf_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ipf_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Sources and CPU side
  input wire logic lvd_req_i,
  input wire logic ctm_req_i,
  input ipf_pkg::ipf_req_t cpu_req_o
);
  import ipf_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rel;
    $fell(sys_rst_i) ##0 (lvd_req_i || ctm_req_i);
  endsequence
  sequence s_ans;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  property p_rst;
    s_rel |=> cpu_req_o.valid && cpu_req_o.level == 4'h4;
  endproperty
  property p_off;
    cpu_req_o.valid |-> cpu_req_o.level != 4'h0;
  endproperty
  property p_top;
    cpu_req_o.valid |-> cpu_req_o.level <= 4'h7;
  endproperty
  property p_idle;
    !lvd_req_i && !ctm_req_i |=> !cpu_req_o.valid;
  endproperty
  property p_ro;
    avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTM_PRI
      |-> avs_readdata_o[15:7] == 9'h000;
  endproperty
  property p_bus;
    $rose(avs_read_i || avs_write_i) |-> s_ans;
  endproperty
  a_rst: assert property (p_rst) else $error("level after reset");
  a_off: assert property (p_off) else $error("level zero shown");
  a_top: assert property (p_top) else $error("level above 7");
  a_idle: assert property (p_idle) else $error("request w/o source");
  a_ro: assert property (p_ro) else $error("upper bits not zero");
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : ipf_checker

bind ipf_top ipf_checker u_ipf_checker (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .lvd_req_i(lvd_req_i), .ctm_req_i(ctm_req_i), .cpu_req_o(cpu_req_o));

// *** dv/ipf_cpu_model.sv ***
// Behavioural CPU core that acknowledges presented requests
`timescale 1ns/1ps
module ipf_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Request side
  input wire logic unack_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_r;
  // One pulse per request, after delay_i idle cycles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !unack_i || ack_o) begin
      wait_r <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
      ack_o <= (wait_r >= delay_i);
    end
  end
endmodule : ipf_cpu_model

// *** dv/tb_top.sv ***
// Self-checking bench for the priority field block
`timescale 1ns/1ps
module tb_top;
  import ipf_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, lvd_req_i = 1'b1, ctm_req_i = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [DATA_W-1:0] avs_writedata_i = '0, avs_readdata_o, q;
  logic cpu_ack_i, unack_o, irq_o;
  logic [3:0] delay = 4'h0;
  ipf_req_t cpu_req_o;
  int mismatches = 0, checks_done = 0;
  always #50 clk_i = ~clk_i;
  ipf_top #(.LVD_VEC(7'h11), .CTM_VEC(7'h2A)) u_ipf_top (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .lvd_req_i(lvd_req_i), .ctm_req_i(ctm_req_i), .cpu_ack_i(cpu_ack_i),
    .cpu_req_o(cpu_req_o), .unack_o(unack_o), .irq_o(irq_o));
  ipf_cpu_model u_ipf_cpu_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .unack_i(unack_o), .delay_i(delay), .ack_o(cpu_ack_i));
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic look(input logic l, input logic c);
    @(posedge clk_i);
    lvd_req_i <= l;
    ctm_req_i <= c;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : look
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    look(1'b1, 1'b0);
    chk("level", {28'h0, cpu_req_o.level}, 32'h4);
    bus(1'b0, OFS_LVD_PRI, 32'h0);
    chk("lvd pri", q, 32'h4);
    bus(1'b0, OFS_CTM_PRI, 32'h0);
    chk("ctm pri", q, 32'h40);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, OFS_CTM_PRI, 32'hFFFF);
    bus(1'b0, OFS_CTM_PRI, 32'h0);
    chk("ctm pri", q, 32'h70);
    bus(1'b1, OFS_CTM_PRI, 32'h0);
    for (int c = 0; c < 8; c++) begin
      delay <= 4'(c);
      bus(1'b1, OFS_LVD_PRI, 32'(c));
      look(1'b1, 1'b1);
      chk("valid", {31'h0, cpu_req_o.valid}, {31'h0, c != 0});
      if (c != 0) begin
        chk("level", {28'h0, cpu_req_o.level}, 32'(c));
      end
    end
    delay <= 4'h0;
    bus(1'b1, OFS_CTM_PRI, 32'h50);
    bus(1'b1, OFS_LVD_PRI, 32'h2);
    look(1'b1, 1'b1);
    chk("vec", {25'h0, cpu_req_o.vec}, 32'h2A);
    // Slow acknowledge keeps the new winner visibly unacknowledged
    delay <= 4'h3;
    bus(1'b1, OFS_LVD_PRI, 32'h6);
    look(1'b1, 1'b1);
    chk("vec", {25'h0, cpu_req_o.vec}, 32'h11);
    chk("unack", {31'h0, unack_o}, 32'h1);
    look(1'b1, 1'b1);
    chk("unack", {31'h0, unack_o}, 32'h0);
    look(1'b0, 1'b0);
    bus(1'b0, OFS_INT_STS, 32'h0);
    chk("status", q, 32'h11);
    bus(1'b1, OFS_INT_STS, 32'h2000);
    bus(1'b0, OFS_INT_STS, 32'h0);
    chk("status", q, 32'h2000);
    bus(1'b0, OFS_EVT_FLG, 32'h0);
    chk("flags", q, 32'h3);
    chk("irq", {31'h0, irq_o}, 32'h0);
    bus(1'b1, OFS_EVT_MSK, 32'h3);
    look(1'b0, 1'b0);
    chk("irq", {31'h0, irq_o}, 32'h1);
    bus(1'b1, OFS_EVT_FLG, 32'h3);
    look(1'b0, 1'b0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    report_and_stop();
  end
endmodule : tb_top

// *** hdl/ipf_arb.sv ***
// Picks the highest-level enabled request among the sources
`timescale 1ns/1ps
module ipf_arb #(
  parameter int unsigned N = 2
) (
  // Sources
  input wire logic [N-1:0] src_req_i,
  input wire logic [N*ipf_pkg::PRI_W-1:0] src_pri_i,
  input wire logic [N*ipf_pkg::VEC_W-1:0] src_vec_i,
  // Winner
  output ipf_pkg::ipf_req_t win_o
);
  import ipf_pkg::*;

  initial begin
    if (N < 1) begin
      $error("ipf_arb needs at least one source");
    end
  end

  always_comb begin
    logic [LVL_W-1:0] lvl;
    lvl = '0;
    win_o = '0;
    // Strictly greater keeps ties on the lowest index
    for (int i = 0; i < N; i++) begin
      lvl = ipf_level(src_pri_i[i*PRI_W +: PRI_W]);
      if (src_req_i[i] && lvl != '0 && lvl > win_o.level) begin
        win_o.valid = 1'b1;
        win_o.level = lvl;
        win_o.vec = src_vec_i[i*VEC_W +: VEC_W];
      end
    end
  end
endmodule : ipf_arb

// *** hdl/ipf_top.sv ***
// Priority fields, arbitration and status registers on an Avalon-MM slave
`timescale 1ns/1ps
module ipf_top #(
  parameter logic [6:0] LVD_VEC = 7'h01, // Vector id, must differ from CTM_VEC
  parameter logic [6:0] CTM_VEC = 7'h02  // Vector id, must differ from LVD_VEC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [ipf_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ipf_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ipf_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt sources, levels
  input wire logic lvd_req_i,
  input wire logic ctm_req_i,
  // CPU side
  input wire logic cpu_ack_i,
  output ipf_pkg::ipf_req_t cpu_req_o,
  output logic unack_o,
  // Event interrupt
  output logic irq_o
);
  import ipf_pkg::*;

  initial begin
    if (LVD_VEC == CTM_VEC) begin
      $error("ipf_top sources need distinct vector ids");
    end
  end

  logic [PRI_W-1:0] lvd_pri_r, lvd_pri_nxt;
  logic [PRI_W-1:0] ctm_pri_r, ctm_pri_nxt;
  logic vcap_r, vcap_nxt;
  logic [NUM_EV-1:0] flg_r, flg_nxt;
  logic [NUM_EV-1:0] msk_r, msk_nxt;
  ipf_req_t cur_r, cur_nxt;
  logic acked_r, acked_nxt;
  logic [VEC_W-1:0] ack_vec_r, ack_vec_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic irq_r, irq_nxt;
  logic unack_r, unack_nxt;

  ipf_req_t win;
  logic acc, wr_lo, wr_hi;
  logic ev_new, ev_ack;
  logic [NUM_EV-1:0] ev_set, ev_clr;
  logic [15:0] sts_word;

  ipf_arb #(
    .N(NUM_SRC)
  ) u_arb (
    .src_req_i({ctm_req_i, lvd_req_i}),
    .src_pri_i({ctm_pri_r, lvd_pri_r}),
    .src_vec_i({CTM_VEC, LVD_VEC}),
    .win_o(win)
  );

  // Access completes in the cycle waitrequest is low
  assign acc = (avs_read_i || avs_write_i) && !wait_r;
  assign wr_lo = acc && avs_write_i && avs_byteenable_i[0];
  assign wr_hi = acc && avs_write_i && avs_byteenable_i[1];

  assign ev_new = win.valid && (!cur_r.valid || win.vec != cur_r.vec);
  assign ev_ack = cpu_ack_i && cur_r.valid && !acked_r;
  assign ev_set = {ev_ack, ev_new};
  assign ev_clr = (wr_lo && avs_address_i == OFS_EVT_FLG) ?
                  avs_writedata_i[NUM_EV-1:0] : '0;

  // Pending vector or the last acknowledged one, as selected
  always_comb begin
    sts_word = '0;
    sts_word[UNACK_POS] = unack_r;
    sts_word[VCAP_POS] = vcap_r;
    sts_word[NEW_LVL_POS +: LVL_W] = cur_r.level;
    sts_word[VEC_ID_POS +: VEC_W] = vcap_r ? cur_r.vec : ack_vec_r;
  end

  // Register file
  always_comb begin
    lvd_pri_nxt = lvd_pri_r;
    ctm_pri_nxt = ctm_pri_r;
    vcap_nxt = vcap_r;
    msk_nxt = msk_r;
    if (wr_lo && avs_address_i == OFS_LVD_PRI) begin
      lvd_pri_nxt = avs_writedata_i[LVD_PRI_POS +: PRI_W];
    end
    // Only bits 6:4 are stored; the rest of the word is dropped
    if (wr_lo && avs_address_i == OFS_CTM_PRI) begin
      ctm_pri_nxt = avs_writedata_i[CTM_PRI_POS +: PRI_W];
    end
    if (wr_hi && avs_address_i == OFS_INT_STS) begin
      vcap_nxt = avs_writedata_i[VCAP_POS];
    end
    if (wr_lo && avs_address_i == OFS_EVT_MSK) begin
      msk_nxt = avs_writedata_i[NUM_EV-1:0];
    end
    // Set wins over a simultaneous write-one clear
    flg_nxt = (flg_r & ~ev_clr) | ev_set;
    irq_nxt = |(flg_nxt & msk_nxt);
  end

  // Bus handshake and read data
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = '0;
      if (avs_read_i) begin
        unique case (avs_address_i)
          OFS_LVD_PRI: rdata_nxt[LVD_PRI_POS +: PRI_W] = lvd_pri_r;
          OFS_CTM_PRI: rdata_nxt[CTM_PRI_POS +: PRI_W] = ctm_pri_r;
          OFS_INT_STS: rdata_nxt[15:0] = sts_word;
          OFS_EVT_FLG: rdata_nxt[NUM_EV-1:0] = flg_r;
          OFS_EVT_MSK: rdata_nxt[NUM_EV-1:0] = msk_r;
          default: rdata_nxt = '0;
        endcase
      end
    end
  end

  // Request tracking toward the CPU
  always_comb begin
    cur_nxt = win;
    acked_nxt = acked_r;
    ack_vec_nxt = ack_vec_r;
    if (ev_ack) begin
      acked_nxt = 1'b1;
      ack_vec_nxt = cur_r.vec;
    end
    // A new winner or none needs a fresh acknowledge
    if (!win.valid || win.vec != cur_r.vec) begin
      acked_nxt = 1'b0;
    end
    unack_nxt = cur_nxt.valid && !acked_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lvd_pri_r <= PRI_RST;
      ctm_pri_r <= PRI_RST;
      vcap_r <= VCAP_RST;
      flg_r <= EV_RST;
      msk_r <= EV_RST;
      cur_r <= '0;
      acked_r <= 1'b0;
      ack_vec_r <= '0;
      rdata_r <= '0;
      wait_r <= 1'b1;
      irq_r <= 1'b0;
      unack_r <= 1'b0;
    end else begin
      lvd_pri_r <= lvd_pri_nxt;
      ctm_pri_r <= ctm_pri_nxt;
      vcap_r <= vcap_nxt;
      flg_r <= flg_nxt;
      msk_r <= msk_nxt;
      cur_r <= cur_nxt;
      acked_r <= acked_nxt;
      ack_vec_r <= ack_vec_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      irq_r <= irq_nxt;
      unack_r <= unack_nxt;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign cpu_req_o = cur_r;
  assign unack_o = unack_r;
  assign irq_o = irq_r;
endmodule : ipf_top

// *** pkg/ipf_pkg.sv ***
// Constants, types and helpers for the interrupt priority field block
package ipf_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PRI_W = 3;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned VEC_W = 7;
  localparam int unsigned NUM_SRC = 2;

  // Byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFS_LVD_PRI = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTM_PRI = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_FLG = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVT_MSK = 5'h10;

  // Field positions
  localparam int unsigned LVD_PRI_POS = 0;
  localparam int unsigned CTM_PRI_POS = 4;
  localparam int unsigned UNACK_POS = 15;
  localparam int unsigned VCAP_POS = 13;
  localparam int unsigned NEW_LVL_POS = 8;
  localparam int unsigned VEC_ID_POS = 0;
  localparam int unsigned EV_NEW_POS = 0;
  localparam int unsigned EV_ACK_POS = 1;
  localparam int unsigned NUM_EV = 2;

  // Reset values, and the code that keeps a source from being presented
  localparam logic [PRI_W-1:0] PRI_RST = 3'h4;
  localparam logic [PRI_W-1:0] PRI_OFF = 3'h0;
  localparam logic VCAP_RST = 1'b0;
  localparam logic [NUM_EV-1:0] EV_RST = 2'h0;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
    logic [VEC_W-1:0] vec;
  } ipf_req_t;

  // Code to CPU level; zero means never presented
  function automatic logic [LVL_W-1:0] ipf_level(input logic [PRI_W-1:0] c);
    ipf_level = {1'b0, c};
  endfunction : ipf_level
endpackage : ipf_pkg
